//--- rtl/rsm_top.sv
// Purpose: Regenerates remote SPI traffic onto a local SPI slave, with config and status
// Assumes: Link clock, link select and link data are pins sampled by REF_CLK
// Notes:   One bit of slack between link and SPI side; a second arrival overflows
`timescale 1ns/1ps
module rsm_top
  import rsm_pkg::*;
(
  input  wire logic        REF_CLK,    // 10 MHz clock
  input  wire logic        RST_N,      // Synchronous reset, active low
  input  wire logic        HSEL,       // AHB slave select
  input  wire logic [31:0] HADDR,      // AHB address
  input  wire logic [1:0]  HTRANS,     // AHB transfer type
  input  wire logic        HWRITE,     // AHB write
  input  wire logic [2:0]  HSIZE,      // AHB size, word only
  input  wire logic [31:0] HWDATA,     // AHB write data
  input  wire logic        HREADY,     // AHB bus ready
  output logic      [31:0] HRDATA,     // AHB read data
  output logic             HREADYOUT,  // AHB slave ready
  output logic             HRESP,      // AHB response, always OKAY
  input  wire logic        LINK_CLK,   // Remote bit clock
  input  wire logic        LINK_SS_N,  // Remote frame, active low
  input  wire logic        LINK_DATA,  // Remote data bit
  output logic             LINK_MISO,  // Captured slave bit back to link
  output logic             SPI_SCLK,   // SPI clock out
  output logic             SPI_MOSI,   // SPI data out
  output logic             SPI_SS_N,   // SPI slave select, active low
  input  wire logic        SPI_MISO,   // SPI data in
  output logic             IRQ         // Level interrupt, active high
);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [3:0] pins_f;
  logic       lclk_f, lss_n_f, ldat_f, miso_f;

  rsm_sync #(.W(4), .RST_VAL(4'h2)) u_sync (
    .REF_CLK (REF_CLK),
    .RST_N   (RST_N),
    .D_IN    ({SPI_MISO, LINK_DATA, LINK_SS_N, LINK_CLK}),
    .Q_OUT   (pins_f)
  );
  assign {miso_f, ldat_f, lss_n_f, lclk_f} = pins_f;

  // ********************************
  // State
  // ********************************
  rsm_timing_s tim_ff, nxt_tim;
  rsm_cfg_s    cfg_ff, nxt_cfg;
  logic [1:0]  sts_ff, nxt_sts, msk_ff, nxt_msk;
  logic        wr_pend_ff, nxt_wr_pend;
  logic [7:0]  wr_idx_ff, nxt_wr_idx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        irq_ff, nxt_irq;
  rsm_state_e  st_ff, nxt_st;
  logic [4:0]  tmr_ff, nxt_tmr, run_ff, nxt_run;
  logic        sclk_ff, nxt_sclk, mosi_ff, nxt_mosi, ss_n_ff, nxt_ss_n;
  logic        miso_ret_ff, nxt_miso_ret, lclk_prev_ff;
  logic        pend_v_ff, nxt_pend_v, pend_bit_ff, nxt_pend_bit;
  logic        addr_ok, lk_take, consume, ovf_evt, done_evt, frame_end, tmr_done;
  logic [4:0]  hold_c, setup_c, lead_c;
  logic [7:0]  wd, rd_byte;
  logic [7:0]  rd_idx;

  assign addr_ok   = HSEL & HREADY & HTRANS[1];
  assign wd        = HWDATA[7:0];
  assign hold_c    = units_to_cyc(tim_ff.hold);
  assign setup_c   = units_to_cyc(tim_ff.setup);
  assign lead_c    = units_to_cyc(tim_ff.lead);
  assign lk_take   = lclk_f & ~lclk_prev_ff & ~lss_n_f;
  assign frame_end = lss_n_f & ~pend_v_ff;
  assign tmr_done  = (tmr_ff <= 5'd1);

  // ********************************
  // SPI regeneration engine
  // ********************************
  // Computes the SPI pins, the one-bit landing slot and the overflow event
  always_comb begin
    nxt_st       = st_ff;
    nxt_tmr      = tmr_done ? tmr_ff : tmr_ff - 5'd1;
    nxt_sclk     = sclk_ff;
    nxt_mosi     = mosi_ff;
    nxt_ss_n     = ss_n_ff;
    nxt_miso_ret = miso_ret_ff;
    consume      = 1'b0;
    done_evt     = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        nxt_sclk = cfg_ff.clock_polarity_setting;
        nxt_ss_n = 1'b1;
        if (pend_v_ff) begin
          nxt_st   = ST_LEAD;
          nxt_ss_n = 1'b0;
          nxt_tmr  = lead_c;
        end
      end
      ST_LEAD: begin
        if (tmr_done) begin
          consume  = 1'b1;
          nxt_mosi = pend_bit_ff;
          nxt_st   = ST_SETUP;
          nxt_tmr  = setup_c;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          nxt_sclk     = ~cfg_ff.clock_polarity_setting;
          nxt_miso_ret = miso_f;
          nxt_st       = ST_HOLD;
          nxt_tmr      = hold_c;
        end
      end
      ST_HOLD, ST_WAIT: begin
        if (tmr_done || st_ff == ST_WAIT) begin
          nxt_sclk = cfg_ff.clock_polarity_setting;
          if (pend_v_ff) begin
            consume  = 1'b1;
            nxt_mosi = pend_bit_ff;
            nxt_st   = ST_SETUP;
            nxt_tmr  = setup_c;
          end else if (frame_end) begin
            nxt_ss_n = 1'b1;
            done_evt = 1'b1;
            nxt_st   = ST_IDLE;
          end else begin
            nxt_st = ST_WAIT;
          end
        end
      end
      default: begin
        nxt_st   = ST_IDLE;
        nxt_ss_n = 1'b1;
      end
    endcase
    // second bit before the first is used
    ovf_evt      = lk_take & pend_v_ff & ~consume;
    nxt_pend_v   = lk_take | (pend_v_ff & ~consume);
    nxt_pend_bit = lk_take ? ldat_f : pend_bit_ff;
    nxt_run      = (nxt_st != st_ff) ? 5'd0 : ((run_ff == 5'h1f) ? run_ff : run_ff + 5'd1);
  end

  // Register the engine
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      st_ff        <= ST_IDLE;
      tmr_ff       <= 5'd0;
      run_ff       <= 5'd0;
      sclk_ff      <= 1'b0;
      mosi_ff      <= 1'b0;
      ss_n_ff      <= 1'b1;
      miso_ret_ff  <= 1'b0;
      lclk_prev_ff <= 1'b0;
      pend_v_ff    <= 1'b0;
      pend_bit_ff  <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      tmr_ff       <= nxt_tmr;
      run_ff       <= nxt_run;
      sclk_ff      <= nxt_sclk;
      mosi_ff      <= nxt_mosi;
      ss_n_ff      <= nxt_ss_n;
      miso_ret_ff  <= nxt_miso_ret;
      lclk_prev_ff <= lclk_f;
      pend_v_ff    <= nxt_pend_v;
      pend_bit_ff  <= nxt_pend_bit;
    end
  end

  // ********************************
  // Register file and AHB-Lite slave
  // ********************************
  // Write lands in the data phase; reads use next values so a read right after a write sees it
  always_comb begin
    nxt_wr_pend = wr_pend_ff;
    nxt_wr_idx  = wr_idx_ff;
    nxt_hrdata  = hrdata_ff;
    nxt_tim     = tim_ff;
    nxt_cfg     = cfg_ff;
    nxt_msk     = msk_ff;
    nxt_sts     = sts_ff;
    rd_idx      = 8'hff;
    rd_byte     = 8'h00;
    if (wr_pend_ff) begin
      case (wr_idx_ff)
        IDX_TIMING1: begin
          nxt_tim.hold  = wd[TIM_HOLD_LSB +: 4];
          nxt_tim.setup = wd[TIM_SETUP_LSB +: 4];
        end
        IDX_TIMING2: nxt_tim.lead = wd[TIM_LEAD_LSB +: 4];
        IDX_CONFIG: begin
          // clear bit holds what was written
          nxt_cfg.regen_overflow_clear   = wd[CFG_CLR_BIT];
          nxt_cfg.clock_polarity_setting = wd[CFG_CPOL_BIT];
        end
        IDX_IRQ_STS: nxt_sts = sts_ff & ~wd[1:0];
        IDX_IRQ_MSK: nxt_msk = wd[1:0];
        default: nxt_msk = msk_ff;
      endcase
    end
    // set wins over a level clear
    nxt_cfg.regen_overflow_flag = ovf_evt | (cfg_ff.regen_overflow_flag & ~cfg_ff.regen_overflow_clear);
    nxt_sts[IRQ_OVF_BIT]  = nxt_sts[IRQ_OVF_BIT] | ovf_evt;
    nxt_sts[IRQ_DONE_BIT] = nxt_sts[IRQ_DONE_BIT] | done_evt;
    nxt_irq = |(nxt_sts & nxt_msk);
    if (addr_ok) begin
      // Unmapped addresses decode to an index that matches nothing
      if (HADDR[11:10] == 2'b00 && HADDR[1:0] == 2'b00) begin
        rd_idx = HADDR[9:2];
      end
      nxt_wr_pend = HWRITE;
      nxt_wr_idx  = rd_idx;
      if (!HWRITE) begin
        case (rd_idx)
          IDX_TIMING1: rd_byte = {nxt_tim.hold, nxt_tim.setup};
          IDX_TIMING2: rd_byte = {4'h0, nxt_tim.lead};
          IDX_CONFIG:  rd_byte = {nxt_cfg.regen_overflow_flag, 4'h0, nxt_cfg.regen_overflow_clear,
                                  1'b0, nxt_cfg.clock_polarity_setting};
          IDX_IRQ_STS: rd_byte = {6'h00, nxt_sts};
          IDX_IRQ_MSK: rd_byte = {6'h00, nxt_msk};
          default:     rd_byte = 8'h00;
        endcase
        nxt_hrdata = {24'h000000, rd_byte};
      end
    end else if (HREADY) begin
      nxt_wr_pend = 1'b0;
    end
  end

  // Register the register file
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      hrdata_ff  <= 32'h00000000;
      tim_ff     <= '{hold: TIMING1_RST[7:4], setup: TIMING1_RST[3:0], lead: TIMING2_RST[3:0]};
      cfg_ff     <= '{regen_overflow_flag: CONFIG_RST[7], regen_overflow_clear: CONFIG_RST[2],
                      clock_polarity_setting: CONFIG_RST[0]};
      sts_ff     <= IRQ_RST;
      msk_ff     <= IRQ_RST;
      irq_ff     <= 1'b0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_idx_ff  <= nxt_wr_idx;
      hrdata_ff  <= nxt_hrdata;
      tim_ff     <= nxt_tim;
      cfg_ff     <= nxt_cfg;
      sts_ff     <= nxt_sts;
      msk_ff     <= nxt_msk;
      irq_ff     <= nxt_irq;
    end
  end

  // Zero-wait slave; single-beat word access only
  assign HRDATA    = hrdata_ff;
  assign HREADYOUT = RST_N | ~RST_N;
  assign HRESP     = 1'b0;
  assign SPI_SCLK  = sclk_ff;
  assign SPI_MOSI  = mosi_ff;
  assign SPI_SS_N  = ss_n_ff;
  assign LINK_MISO = miso_ret_ff;
  assign IRQ       = irq_ff;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_ovf_set: assert property (lk_take && pend_v_ff && !consume |=> cfg_ff.regen_overflow_flag && sts_ff[0])
    else $error("overflow not flagged");
  a_ovf_clear: assert property (cfg_ff.regen_overflow_clear && !ovf_evt |=> !cfg_ff.regen_overflow_flag)
    else $error("overflow not cleared");
  a_ovf_sticky: assert property (cfg_ff.regen_overflow_flag && !cfg_ff.regen_overflow_clear
                                 |=> cfg_ff.regen_overflow_flag)
    else $error("overflow flag dropped");
  a_clr_keep: assert property (!(wr_pend_ff && wr_idx_ff == IDX_CONFIG) |=> $stable(cfg_ff.regen_overflow_clear))
    else $error("clear bit changed alone");
  a_phase_zero: assert property (addr_ok && !HWRITE && HADDR[11:0] == reg_addr(IDX_CONFIG)
                                 |=> HRDATA[CFG_CPHA_BIT] == 1'b0)
    else $error("phase bit not zero");
  a_idle_level: assert property (st_ff == ST_IDLE |=> SPI_SCLK == $past(cfg_ff.clock_polarity_setting))
    else $error("idle clock level wrong");
  a_active_edge: assert property (st_ff == ST_HOLD |-> SPI_SCLK != cfg_ff.clock_polarity_setting)
    else $error("active phase level wrong");
  a_hold_width: assert property (st_ff == ST_HOLD && nxt_st != ST_HOLD |-> run_ff + 5'd1 >= hold_c)
    else $error("hold too short");
  a_mosi_stable: assert property (st_ff == ST_HOLD && $past(st_ff) == ST_HOLD |-> $stable(SPI_MOSI))
    else $error("data moved in hold");
  a_setup_width: assert property (st_ff == ST_SETUP && nxt_st != ST_SETUP |-> run_ff + 5'd1 >= setup_c)
    else $error("setup too short");
  a_lead_width: assert property (st_ff == ST_LEAD && nxt_st != ST_LEAD |-> run_ff + 5'd1 >= lead_c)
    else $error("select lead too short");
  a_select_frame: assert property (st_ff != ST_IDLE |-> !SPI_SS_N)
    else $error("select high in transfer");

  c_frame_done: cover property (done_evt);
  c_overflow: cover property (ovf_evt);
  c_cpol_xfer: cover property (cfg_ff.clock_polarity_setting && st_ff == ST_HOLD);
  c_irq_raise: cover property (!IRQ ##1 IRQ);

endmodule

//--- rtl/rsm_pkg.sv
// Purpose: Constants, types and register map of the remote SPI master regenerator
// Assumes: 10 MHz reference clock, AHB-Lite register access with 32-bit data
// Notes:   Printed offsets are register indices; byte address is four times the index
package rsm_pkg;

  // ********************************
  // Register indices and byte addresses
  // ********************************
  localparam logic [7:0] IDX_TIMING1 = 8'h60;
  localparam logic [7:0] IDX_TIMING2 = 8'h61;
  localparam logic [7:0] IDX_CONFIG  = 8'h62;
  localparam logic [7:0] IDX_IRQ_STS = 8'h70;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h71;

  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int         CFG_OVF_BIT   = 7;
  localparam int         CFG_CLR_BIT   = 2;
  localparam int         CFG_CPHA_BIT  = 1;
  localparam int         CFG_CPOL_BIT  = 0;
  localparam int         TIM_HOLD_LSB  = 4;
  localparam int         TIM_SETUP_LSB = 0;
  localparam int         TIM_LEAD_LSB  = 0;
  localparam int         IRQ_OVF_BIT   = 0;
  localparam int         IRQ_DONE_BIT  = 1;
  localparam logic [7:0] TIMING1_RST   = 8'h22;
  localparam logic [7:0] TIMING2_RST   = 8'h02;
  localparam logic [7:0] CONFIG_RST    = 8'h00;
  localparam logic [1:0] IRQ_RST       = 2'h0;

  // ********************************
  // Timing: settings count in 40 ns units
  // ********************************
  localparam int UNIT_NS       = 40;
  localparam int CLK_PERIOD_NS = 100;

  // Least time, so round up; never below one cycle
  function automatic logic [4:0] units_to_cyc(input logic [3:0] n);
    int t;
    t = ((int'(n) + 1) * UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (t < 1) begin
      t = 1;
    end
    return t[4:0];
  endfunction

  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LEAD  = 3'b001,
    ST_SETUP = 3'b011,
    ST_HOLD  = 3'b010,
    ST_WAIT  = 3'b110
  } rsm_state_e;

  typedef struct packed {
    logic [3:0] hold;
    logic [3:0] setup;
    logic [3:0] lead;
  } rsm_timing_s;

  typedef struct packed {
    logic regen_overflow_flag;
    logic regen_overflow_clear;
    logic clock_polarity_setting;
  } rsm_cfg_s;

endpackage

//--- rtl/rsm_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to REF_CLK
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
module rsm_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         REF_CLK, // Reference clock
  input  wire logic         RST_N,   // Synchronous reset, active low
  input  wire logic [W-1:0] D_IN,    // Asynchronous inputs
  output logic      [W-1:0] Q_OUT    // Filtered, synchronised levels
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [W-1:0] nxt_q;

  // Only stage two reads stage one; the filter looks at two and three
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  // Register stages
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      q_ff  <= RST_VAL;
    end else begin
      s1_ff <= D_IN;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign Q_OUT = q_ff;

endmodule

//--- testbench/rsm_spi_slave.sv
// Purpose: Local SPI slave model on the regenerated bus
// Assumes: Leading edge is the one that leaves the idle level set by polarity
// Notes:   Records timing margins of each frame for the bench to judge
`timescale 1ns/1ps
module rsm_spi_slave (
  input  wire logic sclk, // SPI clock from the master
  input  wire logic ss_n, // Select, active low
  input  wire logic mosi, // Data from the master
  input  wire logic cpol, // Polarity the bench programmed
  output logic      miso  // Data back to the master
);
  logic [7:0] rx;
  int         cnt;
  realtime    t_ss, t_mosi, t_lead, t_trail, lead_ns, min_setup, min_hold, min_active, min_idle;

  function automatic realtime lo(input realtime a, input realtime b);
    return (a < b) ? a : b;
  endfunction

  // ********************************
  // Frame tracking
  // ********************************
  initial begin
    miso = 1'b0;
    cnt = 0;
    t_mosi = 0;
  end
  // New frame restarts every margin
  always @(negedge ss_n) begin
    cnt = 0;
    t_ss = $realtime;
    min_setup = 1e9;
    min_hold = 1e9;
    min_active = 1e9;
    min_idle = 1e9;
  end
  // A data move soon after a capture edge eats into hold
  always @(mosi) begin
    min_hold = (!ss_n && cnt > 0) ? lo(min_hold, $realtime - t_lead) : min_hold;
    t_mosi = $realtime;
  end
  always @(sclk) begin
    if (!ss_n && sclk !== cpol) begin
      rx = {rx[6:0], mosi};
      lead_ns = (cnt == 0) ? $realtime - t_ss : lead_ns;
      min_idle = (cnt > 0) ? lo(min_idle, $realtime - t_trail) : min_idle;
      min_setup = lo(min_setup, $realtime - t_mosi);
      t_lead = $realtime;
      cnt++;
    end else if (!ss_n) begin
      min_active = lo(min_active, $realtime - t_lead);
      t_trail = $realtime;
      // Echo the captured bit, inverted after odd counts, not the data line, which may move at this same instant
      miso = rx[0] ^ cnt[0];
    end
  end
  // Released line shows no stale value
  always @(posedge ss_n) begin
    miso = ~miso;
  end
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the remote SPI regenerator
// Assumes: Zero-wait AHB slave; link bits every 800 ns
// Notes:   Link clock stands still between frames
`timescale 1ns/1ps
module tb_top;
  import rsm_pkg::*;
  logic        REF_CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, cpol;
  logic        LINK_CLK, LINK_SS_N, LINK_DATA, LINK_MISO, SPI_SCLK, SPI_MOSI, SPI_SS_N, SPI_MISO;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, seed;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  int          error_cnt, samples_checked;
  logic [7:0]  ridx [6] = '{IDX_TIMING1, IDX_TIMING2, IDX_CONFIG, IDX_IRQ_STS, IDX_IRQ_MSK, 8'h7f};
  logic [7:0]  rexp [6] = '{8'h22, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        cp [3] = '{1'b0, 1'b1, 1'b0};
  logic [7:0]  t1 [3] = '{8'h22, 8'h54, 8'h00};
  logic [7:0]  t2 [3] = '{8'h02, 8'h03, 8'h00};

  rsm_top dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK_CLK(LINK_CLK), .LINK_SS_N(LINK_SS_N),
    .LINK_DATA(LINK_DATA), .LINK_MISO(LINK_MISO), .SPI_SCLK(SPI_SCLK), .SPI_MOSI(SPI_MOSI),
    .SPI_SS_N(SPI_SS_N), .SPI_MISO(SPI_MISO), .IRQ(IRQ));
  rsm_spi_slave slave (.sclk(SPI_SCLK), .ss_n(SPI_SS_N), .mosi(SPI_MOSI), .cpol(cpol), .miso(SPI_MISO));

  // ********************************
  // Helpers
  // ********************************
  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Least time of a setting in 40 ns units
  function automatic int ns(input logic [3:0] n);
    return (int'(n) + 1) * 40;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded wait for the slave to be ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge REF_CLK);
    while (HREADYOUT !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        stop_test();
      end
      @(posedge REF_CLK);
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {22'h0, idx, 2'b00};
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, wd};
    wait_rdy();
    rd = HRDATA;
  endtask
  // Link frame, MSB first; the link clock only moves inside it
  task automatic link_frame(input logic [7:0] b);
    int n;
    LINK_SS_N <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    for (int i = 7; i >= 0; i--) begin
      LINK_DATA <= b[i];
      repeat (4) @(posedge REF_CLK);
      LINK_CLK <= 1'b1;
      repeat (4) @(posedge REF_CLK);
      LINK_CLK <= 1'b0;
    end
    LINK_SS_N <= 1'b1;
    LINK_DATA <= ~b[0];
    n = 0;
    @(posedge REF_CLK);
    while (SPI_SS_N !== 1'b1) begin
      n++;
      if (n > 400) begin
        error_cnt++;
        stop_test();
      end
      @(posedge REF_CLK);
    end
    repeat (2) @(posedge REF_CLK);
  endtask

  // ********************************
  // Sequence
  // ********************************
  initial begin
    {RST_N, HSEL, HADDR, HTRANS, HWRITE, HWDATA, LINK_CLK, LINK_DATA, cpol} = '0;
    HSIZE = 3'b010;
    LINK_SS_N = 1'b1;
    seed = 32'h292a;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      ahb(1'b0, ridx[k], 8'h00);
      check("reset_value", rd, {24'h0, rexp[k]});
    end
    ahb(1'b1, 8'h7f, 8'hff);
    ahb(1'b0, 8'h7f, 8'h00);
    check("unmapped", rd, 32'h0);
    check("hresp", {31'h0, HRESP}, 32'h0);
    ahb(1'b1, IDX_CONFIG, 8'hfb);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("config_ro", rd, 32'h01);
    ahb(1'b1, IDX_CONFIG, 8'h00);
    // Slowest settings cannot keep up with the link
    ahb(1'b1, IDX_TIMING1, 8'hff);
    ahb(1'b1, IDX_TIMING2, 8'h0f);
    seed = lfsr(seed);
    link_frame(seed[7:0]);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("ovf_flag", rd, 32'h80);
    ahb(1'b0, IDX_IRQ_STS, 8'h00);
    check("irq_status", rd, 32'h3);
    check("irq_masked", {31'h0, IRQ}, 32'h0);
    ahb(1'b1, IDX_IRQ_MSK, 8'h01);
    repeat (2) @(posedge REF_CLK);
    check("irq_raised", {31'h0, IRQ}, 32'h1);
    ahb(1'b1, IDX_IRQ_STS, 8'h01);
    repeat (2) @(posedge REF_CLK);
    check("irq_cleared", {31'h0, IRQ}, 32'h0);
    ahb(1'b1, IDX_IRQ_STS, 8'h02);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("flag_sticky", rd, 32'h80);
    ahb(1'b1, IDX_CONFIG, 8'h04);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("flag_clear", rd, 32'h04);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("clear_holds", rd, 32'h04);
    // software writes the clear bit back
    ahb(1'b1, IDX_CONFIG, 8'h00);
    ahb(1'b0, IDX_CONFIG, 8'h00);
    check("clear_back", rd, 32'h00);
    for (int k = 0; k < 3; k++) begin
      cpol <= cp[k];
      ahb(1'b1, IDX_CONFIG, {7'h0, cp[k]});
      ahb(1'b1, IDX_TIMING1, t1[k]);
      ahb(1'b1, IDX_TIMING2, t2[k]);
      check("sclk_idle", {31'h0, SPI_SCLK}, {31'h0, cp[k]});
      seed = lfsr(seed);
      link_frame(seed[7:0]);
      check("rx_byte", {24'h0, slave.rx}, {24'h0, seed[7:0]});
      check("rx_count", slave.cnt, 32'd8);
      check("lead", 32'(slave.lead_ns >= ns(t2[k][3:0]) + ns(t1[k][3:0])), 32'h1);
      check("setup", 32'(slave.min_setup >= ns(t1[k][3:0])), 32'h1);
      check("inactive", 32'(slave.min_idle >= ns(t1[k][3:0])), 32'h1);
      check("hold", 32'(slave.min_hold >= ns(t1[k][7:4])), 32'h1);
      check("active", 32'(slave.min_active >= ns(t1[k][7:4])), 32'h1);
      check("sclk_rest", {31'h0, SPI_SCLK}, {31'h0, cp[k]});
      // Last leading edge returns the slave's inverted echo of the seventh bit
      check("link_miso", {31'h0, LINK_MISO}, {31'h0, ~seed[1]});
      ahb(1'b0, IDX_CONFIG, 8'h00);
      check("no_overflow", rd, {31'h0, cp[k]});
      ahb(1'b0, IDX_IRQ_STS, 8'h00);
      check("frame_done", rd, 32'h2);
      ahb(1'b1, IDX_IRQ_STS, 8'h02);
    end
    stop_test();
  end
endmodule
